// File: qdsl_pkg.sv
package qdsl_pkg;

    localparam int          QDSL_CHANNELS      = 4;
    localparam int          QDSL_CODE_W        = 12;
    localparam int          QDSL_SHIFT_W       = 16;

    // Wide variant: 16-bit word
    localparam int          QDSL_W_ALL_OFF_POS = 15;
    localparam int          QDSL_W_CH_OFF_POS  = 14;
    localparam int          QDSL_W_SEL_HI_POS  = 13;
    localparam int          QDSL_W_SEL_LO_POS  = 12;
    localparam int          QDSL_W_CODE_W      = 12;

    // Narrow variant: 14-bit word
    localparam int          QDSL_N_ALL_OFF_POS = 13;
    localparam int          QDSL_N_CH_OFF_POS  = 12;
    localparam int          QDSL_N_SEL_HI_POS  = 11;
    localparam int          QDSL_N_SEL_LO_POS  = 10;
    localparam int          QDSL_N_CODE_W      = 10;

    localparam logic [11:0] QDSL_CODE_RESET    = 12'h000;
    localparam logic [15:0] QDSL_SHIFT_RESET   = 16'h0000;
    localparam logic [3:0]  QDSL_OFF_RESET     = 4'h0;

    typedef enum logic [1:0] {
        QDSL_CH_A = 2'b00,
        QDSL_CH_B = 2'b01,
        QDSL_CH_C = 2'b10,
        QDSL_CH_D = 2'b11
    } qdsl_chan_t;

    typedef struct packed {
        logic                   all_shutdown_bit;
        logic                   channel_shutdown_bit;
        qdsl_chan_t             sel;
        logic [QDSL_CODE_W-1:0] code;
    } qdsl_word_t;

endpackage

// File: qdsl_link_if.sv
`timescale 1ns/1ns
interface qdsl_link_if;
    import qdsl_pkg::*;

    logic [QDSL_SHIFT_W-1:0] word;

    modport shifter (output word);
    modport core    (input  word);
endinterface

// File: qdsl_shift.sv
`timescale 1ns/1ns
module qdsl_shift
    import qdsl_pkg::*;
(
    input  wire logic  sclk,
    input  wire logic  rst_n,
    input  wire logic  cs_n,
    input  wire logic  sdi,
    qdsl_link_if.shifter link
);

    typedef struct packed {
        logic [QDSL_SHIFT_W-1:0] sreg;
    } qdsl_shift_state_t;

    qdsl_shift_state_t st;
    qdsl_shift_state_t next_st;

    // Chip select comes from the same controller as the serial clock and is
    // set up ahead of the first edge, so it gates the shift directly.
    always_comb begin
        next_st = st;
        if (!cs_n) begin
            next_st.sreg = {st.sreg[QDSL_SHIFT_W-2:0], sdi};
        end
    end

    // Only the power-on reset clears the word; zero reset leaves it.
    always_ff @(posedge sclk or negedge rst_n) begin
        if (!rst_n) begin
            st.sreg <= QDSL_SHIFT_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign link.word = st.sreg;

endmodule

// File: qdsl_sync3.sv
`timescale 1ns/1ns
module qdsl_sync3
    import qdsl_pkg::*;
#(
    parameter logic RESET_VAL = 1'b1
)
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic d,
    output logic      q
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic level;
    } qdsl_sync_state_t;

    qdsl_sync_state_t st;
    qdsl_sync_state_t next_st;

    // A change is accepted only once stages two and three agree.
    always_comb begin
        next_st    = st;
        next_st.s1 = d;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (st.s2 == st.s3) begin
            next_st.level = st.s3;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= {4{RESET_VAL}};
        end else begin
            st <= next_st;
        end
    end

    assign q = st.level;

endmodule

// File: qdsl_quad_dac_ctl.sv
`timescale 1ns/1ns
module qdsl_quad_dac_ctl
    import qdsl_pkg::*;
#(
    parameter logic WIDE_VARIANT = 1'b1
)
(
    input  wire logic                                    ref_clk,
    input  wire logic                                    rst_n,
    input  wire logic                                    sclk,
    input  wire logic                                    cs_n,
    input  wire logic                                    sdi,
    input  wire logic                                    load_strobe_n,
    input  wire logic                                    zero_reset_n,
    output logic [QDSL_CHANNELS-1:0][QDSL_CODE_W-1:0]    input_code,
    output logic [QDSL_CHANNELS-1:0][QDSL_CODE_W-1:0]    dac_code,
    output logic [QDSL_CHANNELS-1:0][QDSL_CODE_W-1:0]    out_code,
    output logic [QDSL_CHANNELS-1:0]                     chan_shutdown,
    output logic                                         word_commit
);

    typedef struct packed {
        logic                                        cs_prev;
        logic                                        commit;
        logic [QDSL_CHANNELS-1:0]                    off;
        logic [QDSL_CHANNELS-1:0][QDSL_CODE_W-1:0]   in_reg;
        logic [QDSL_CHANNELS-1:0][QDSL_CODE_W-1:0]   dac_reg;
        logic [QDSL_CHANNELS-1:0][QDSL_CODE_W-1:0]   out_reg;
    } qdsl_core_state_t;

    qdsl_core_state_t st;
    qdsl_core_state_t next_st;

    qdsl_link_if link ();

    logic cs_level;
    logic load_level_n;
    logic clr_raw_n;
    logic clr_n;

    // Split a received word into its fields for the chosen variant.
    function automatic qdsl_word_t qdsl_decode(
        input logic [QDSL_SHIFT_W-1:0] w,
        input logic                    wide
    );
        qdsl_word_t f;
        if (wide) begin
            f.all_shutdown_bit     = w[QDSL_W_ALL_OFF_POS];
            f.channel_shutdown_bit = w[QDSL_W_CH_OFF_POS];
            f.sel                  = qdsl_chan_t'(
                {w[QDSL_W_SEL_HI_POS], w[QDSL_W_SEL_LO_POS]});
            f.code                 = w[QDSL_W_CODE_W-1:0];
        end else begin
            f.all_shutdown_bit     = w[QDSL_N_ALL_OFF_POS];
            f.channel_shutdown_bit = w[QDSL_N_CH_OFF_POS];
            f.sel                  = qdsl_chan_t'(
                {w[QDSL_N_SEL_HI_POS], w[QDSL_N_SEL_LO_POS]});
            f.code                 = {2'h0, w[QDSL_N_CODE_W-1:0]};
        end
        return f;
    endfunction

    qdsl_shift u_shift (
        .sclk  (sclk),
        .rst_n (rst_n),
        .cs_n  (cs_n),
        .sdi   (sdi),
        .link  (link.shifter)
    );

    qdsl_sync3 #(.RESET_VAL(1'b1)) u_cs_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .d       (cs_n),
        .q       (cs_level)
    );

    // Strobe synchronised on its own reset so zero reset cannot fake a load.
    qdsl_sync3 #(.RESET_VAL(1'b1)) u_load_sync (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .d       (load_strobe_n),
        .q       (load_level_n)
    );

    // Either reset clears at once; release is resynchronised to ref_clk so
    // no core register leaves reset in a metastable state.
    assign clr_raw_n = rst_n & zero_reset_n;

    qdsl_sync3 #(.RESET_VAL(1'b0)) u_clr_sync (
        .ref_clk (ref_clk),
        .rst_n   (clr_raw_n),
        .d       (1'b1),
        .q       (clr_n)
    );

    always_comb begin
        qdsl_word_t f;
        f              = qdsl_decode(link.word, WIDE_VARIANT);
        next_st        = st;
        next_st.cs_prev = cs_level;
        next_st.commit = 1'b0;

        // The word is read only after chip select is seen high; the serial
        // clock must stay still by then, so the word is quasi-static.
        if (cs_level && !st.cs_prev) begin
            next_st.commit = 1'b1;
            if (f.all_shutdown_bit) begin
                next_st.off = {QDSL_CHANNELS{1'b1}};
            end else if (f.channel_shutdown_bit) begin
                next_st.off[f.sel] = 1'b1;
            end else begin
                next_st.in_reg[f.sel] = f.code;
                next_st.off[f.sel]    = 1'b0;
            end
        end

        // Transparent while low, so a commit in the same cycle reaches dac_reg
        // on the same edge as in_reg; latched once the strobe is high.
        if (!load_level_n) begin
            next_st.dac_reg = next_st.in_reg;
        end

        // A channel in shutdown holds its output; new codes show on wake.
        for (int i = 0; i < QDSL_CHANNELS; i++) begin
            if (!next_st.off[i]) begin
                next_st.out_reg[i] = next_st.dac_reg[i];
            end
        end
    end

    always_ff @(posedge ref_clk or negedge clr_n) begin
        if (!clr_n) begin
            st.cs_prev <= 1'b1;
            st.commit  <= 1'b0;
            st.off     <= QDSL_OFF_RESET;
            st.in_reg  <= {QDSL_CHANNELS{QDSL_CODE_RESET}};
            st.dac_reg <= {QDSL_CHANNELS{QDSL_CODE_RESET}};
            st.out_reg <= {QDSL_CHANNELS{QDSL_CODE_RESET}};
        end else begin
            st <= next_st;
        end
    end

    assign input_code    = st.in_reg;
    assign dac_code      = st.dac_reg;
    assign out_code      = st.out_reg;
    assign chan_shutdown = st.off;
    assign word_commit   = st.commit;

endmodule

// File: qdsl_sva.sv
`timescale 1ns/1ns
module qdsl_sva
    import qdsl_pkg::*;
(
    input wire logic                                 ref_clk,
    input wire logic                                 rst_n,
    input wire logic                                 sclk,
    input wire logic                                 cs_n,
    input wire logic                                 sdi,
    input wire logic                                 load_strobe_n,
    input wire logic                                 zero_reset_n,
    input wire logic [QDSL_CHANNELS-1:0][QDSL_CODE_W-1:0] input_code,
    input wire logic [QDSL_CHANNELS-1:0][QDSL_CODE_W-1:0] dac_code,
    input wire logic [QDSL_CHANNELS-1:0][QDSL_CODE_W-1:0] out_code,
    input wire logic [QDSL_CHANNELS-1:0]             chan_shutdown,
    input wire logic                                 word_commit
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_pulse; word_commit |=> !word_commit; endproperty
    a_pulse: assert property (p_pulse) else $error("commit too long");
    property p_lat; $rose(cs_n) |-> ##[2:6] word_commit; endproperty
    a_lat: assert property (p_lat) else $error("no commit");
    property p_in;
        $changed(input_code) |-> word_commit || !zero_reset_n;
    endproperty
    a_in: assert property (p_in) else $error("input moved");
    property p_sd;
        $changed(chan_shutdown) |-> word_commit || !zero_reset_n;
    endproperty
    a_sd: assert property (p_sd) else $error("shutdown moved");
    property p_zero;
        !zero_reset_n |-> input_code == '0 && dac_code == '0;
    endproperty
    a_zero: assert property (p_zero) else $error("not cleared");
    property p_hold;
        load_strobe_n [*6] |-> $stable(dac_code) || !zero_reset_n;
    endproperty
    a_hold: assert property (p_hold) else $error("dac moved");
    // Transparent path: a commit reaches both registers on the same edge
    property p_follow;
        (!load_strobe_n && zero_reset_n) [*6] |-> dac_code == input_code;
    endproperty
    a_follow: assert property (p_follow) else $error("dac lag");
    property p_off;
        chan_shutdown[0] && $past(chan_shutdown[0]) |-> $stable(out_code[0]);
    endproperty
    a_off: assert property (p_off) else $error("out moved");
    property p_on;
        !chan_shutdown[0] && !$past(chan_shutdown[0]) |->
            out_code[0] == dac_code[0];
    endproperty
    a_on: assert property (p_on) else $error("out stale");
    c_commit: cover property (word_commit);
    c_all_off: cover property (chan_shutdown == 4'hf);
    c_load: cover property (!load_strobe_n [*6]);
endmodule
bind qdsl_quad_dac_ctl qdsl_sva u_sva (
    .ref_clk       (ref_clk),
    .rst_n         (rst_n),
    .sclk          (sclk),
    .cs_n          (cs_n),
    .sdi           (sdi),
    .load_strobe_n (load_strobe_n),
    .zero_reset_n  (zero_reset_n),
    .input_code    (input_code),
    .dac_code      (dac_code),
    .out_code      (out_code),
    .chan_shutdown (chan_shutdown),
    .word_commit   (word_commit)
);

// File: qdsl_host.sv
`timescale 1ns/1ns
module qdsl_host (
    output logic sclk,
    output logic cs_n,
    output logic sdi
);
    initial begin
        sclk = 1'b0;
        cs_n = 1'b1;
        sdi  = 1'b0;
    end
    // Clock stands still outside frames; the caller lays out the word
    task automatic send(logic [15:0] w, int n);
        int i;
        #640;
        cs_n = 1'b0;
        #400;
        for (i = n - 1; i >= 0; i--) begin
            sdi = w[i];
            #32 sclk = 1'b1;
            #32 sclk = 1'b0;
        end
        #32 cs_n = 1'b1;
        sdi = ~sdi; // Released line shows no valid bit
    endtask
endmodule

// File: tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import qdsl_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic load_strobe_n = 1'b1;
    logic zero_reset_n = 1'b1;
    logic sclk, cs_n, sdi, word_commit;
    logic [3:0][11:0] input_code, dac_code, out_code;
    logic [3:0] chan_shutdown;
    int fail_count = 0;
    int n_tests = 0;
    int cyc = 0;
    always #50 ref_clk = ~ref_clk;
    qdsl_host host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi));
    qdsl_quad_dac_ctl DUT (.ref_clk(ref_clk), .rst_n(rst_n), .sclk(sclk),
        .cs_n(cs_n), .sdi(sdi), .load_strobe_n(load_strobe_n),
        .zero_reset_n(zero_reset_n), .input_code(input_code),
        .dac_code(dac_code), .out_code(out_code),
        .chan_shutdown(chan_shutdown), .word_commit(word_commit));
    // Narrow variant on the same link; it also sees every wide frame
    logic [3:0][11:0] n_input_code;
    logic [3:0] n_chan_shutdown;
    logic n_word_commit;
    qdsl_quad_dac_ctl #(.WIDE_VARIANT(1'b0)) DUT_N (.ref_clk(ref_clk),
        .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .sdi(sdi),
        .load_strobe_n(load_strobe_n), .zero_reset_n(zero_reset_n),
        .input_code(n_input_code), .dac_code(), .out_code(),
        .chan_shutdown(n_chan_shutdown), .word_commit(n_word_commit));
    task automatic chk(string nm, logic [47:0] exp, logic [47:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic put(logic [15:0] w, int n);
        int k;
        host.send(w, n);
        for (k = 0; k < 20 && word_commit !== 1'b1; k++)
            @(negedge ref_clk);
        chk("commit", 1'b1, word_commit);
    endtask
    task automatic t_por();
        chk("por", '0, input_code);
        chk("por", '0, dac_code);
        chk("n por", '0, n_input_code);
        $display("t_por done");
    endtask
    task automatic t_write();
        int c;
        for (c = 0; c < 4; c++) begin
            put({2'b00, c[1:0], 12'ha50 + 12'(c)}, 16);
            chk("in", 12'ha50 + 12'(c), input_code[c]);
        end
        chk("dac", '0, dac_code);
        $display("t_write done");
    endtask
    task automatic t_load();
        int c;
        load_strobe_n = 1'b0;
        repeat (8) @(negedge ref_clk);
        for (c = 0; c < 4; c++)
            chk("dac", 12'ha50 + 12'(c), dac_code[c]);
        load_strobe_n = 1'b1;
        repeat (8) @(negedge ref_clk);
        put(16'h0123, 16);
        chk("in A", 12'h123, input_code[0]);
        chk("dac A", 12'ha50, dac_code[0]);
        $display("t_load done");
    endtask
    task automatic t_shut();
        load_strobe_n = 1'b0;
        put(16'h5fff, 16);
        chk("shut", 4'h2, chan_shutdown);
        put(16'hbabc, 16);
        chk("shut", 4'hf, chan_shutdown);
        chk("in", 48'ha53a52a51123, input_code);
        put(16'h0456, 16);
        repeat (8) @(negedge ref_clk);
        chk("shut", 4'he, chan_shutdown);
        chk("out A", 12'h456, out_code[0]);
        chk("out B", 12'ha51, out_code[1]);
        load_strobe_n = 1'b1;
        $display("t_shut done");
    endtask
    task automatic t_zero();
        zero_reset_n = 1'b0;
        #5;
        chk("in", '0, input_code);
        chk("dac", '0, dac_code);
        @(negedge ref_clk);
        zero_reset_n = 1'b1;
        repeat (8) @(negedge ref_clk);
        // Empty frame recommits whatever the shift register still holds
        put(16'h0000, 0);
        chk("in A", 12'h456, input_code[0]);
        $display("t_zero done");
    endtask
    // Zero reset cleared the narrow flags; the empty frame wrote channel B
    task automatic t_narrow();
        put(16'h0aa5, 14);
        chk("n commit", 1'b1, n_word_commit);
        chk("n in C", 12'h2a5, n_input_code[2]);
        put(16'h1c00, 14);
        chk("n shut", 4'h8, n_chan_shutdown);
        $display("t_narrow done");
    endtask
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fail_count++;
            final_report();
        end
    end
    initial begin
        repeat (20) @(negedge ref_clk);
        rst_n = 1'b1;
        repeat (8) @(negedge ref_clk);
        t_por();
        t_write();
        t_load();
        t_shut();
        t_zero();
        t_narrow();
        final_report();
    end
endmodule
